// ==== verilog/occ_top.sv ====
// oscillator control: run enables, start-up counting, output gates, trims
// assumes oscillator clocks arrive as plain pins sampled on sys_clk (much faster),
// and request, standby and protection inputs come from logic on sys_clk
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
module occ_top
  import occ_pkg::*;
#(
  parameter logic [16:0] XO_STARTUP_1K = 17'h00400,
  parameter logic [16:0] XO_STARTUP_16K = 17'h04000,
  parameter logic [16:0] XO_STARTUP_32K = 17'h08000,
  parameter logic [16:0] XO_STARTUP_64K = 17'h10000,
  parameter logic [16:0] FAST_ANALOG_STARTUP = 17'h00010,
  parameter logic [16:0] SLOW_ANALOG_STARTUP = 17'h00010,
  parameter logic [6:0] FACTORY_FINE_TRIM_A = 7'h40,
  parameter logic [6:0] FACTORY_FINE_TRIM_B = 7'h40,
  parameter logic [3:0] FACTORY_TEMP_SLOPE_A = 4'h8,
  parameter logic [3:0] FACTORY_TEMP_SLOPE_B = 4'h8
) (
  input wire logic sys_clk, // system clock, 250 MHz
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic [7:0] reg_addr, // register offset
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  input wire logic protect_unlock, // protection unlocked for this write
  input wire logic [1:0] fuse_frequency_select, // fuse frequency select
  input wire logic fuse_calibration_lock, // fuse calibration lock
  input wire logic fast_osc_clk, // fast internal oscillator pin
  input wire logic slow_osc_clk, // slow internal oscillator pin
  input wire logic crystal_clk, // crystal or external clock pin
  input wire logic fast_osc_req, // peripheral request, fast oscillator
  input wire logic slow_osc_req, // peripheral request, slow oscillator
  input wire logic crystal_req, // peripheral request, crystal
  output logic fast_osc_run, // fast oscillator analog enable
  output logic slow_osc_run, // slow oscillator analog enable
  output logic crystal_run, // crystal oscillator analog enable
  output logic fast_osc_gate, // fast oscillator output gate open
  output logic slow_osc_gate, // slow oscillator output gate open
  output logic crystal_gate, // crystal output gate open
  output logic crystal_pin_override, // both pins given to crystal function
  output logic [6:0] fast_osc_fine_trim_field, // fine trim to analog
  output logic [3:0] fast_osc_temp_slope_field // temperature slope to analog
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic fast_keep_running_in_standby;
  logic slow_keep_running_in_standby;
  logic crystal_enable;
  logic crystal_keep_running_in_standby;
  logic crystal_source_sel;
  logic [1:0] crystal_startup_select;
  logic cal_lock;
  logic fuse_loaded;
  logic [NUM_OSC-1:0] stable;
  logic crystal_stable_flag;

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  wire logic wr_fast_ctl = reg_wr && protect_unlock && (reg_addr == OFS_FAST_OSC_CONTROL);
  wire logic wr_slow_ctl = reg_wr && protect_unlock && (reg_addr == OFS_SLOW_OSC_CONTROL);
  wire logic wr_xo_ctl = reg_wr && protect_unlock && (reg_addr == OFS_CRYSTAL_OSC_CONTROL);
  wire logic wr_fine = reg_wr && protect_unlock && !cal_lock && (reg_addr == OFS_FAST_OSC_FINE_TRIM);
  wire logic wr_temp = reg_wr && protect_unlock && !cal_lock && (reg_addr == OFS_FAST_OSC_TEMP_TRIM_LOCK);
  wire logic xo_fields_open = !crystal_enable && !crystal_stable_flag;
  wire logic fuse_pick_a = fuse_frequency_select[0];

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_keep_running_in_standby <= 1'b0;
      slow_keep_running_in_standby <= 1'b0;
      crystal_enable <= RST_CONTROL[POS_CRYSTAL_ENABLE];
      crystal_keep_running_in_standby <= RST_CONTROL[POS_KEEP_RUNNING];
      crystal_source_sel <= RST_CONTROL[POS_CRYSTAL_SOURCE_SEL];
      crystal_startup_select <= RST_CONTROL[POS_CRYSTAL_STARTUP_LO+:2];
    end else begin
      if (wr_fast_ctl) begin
        fast_keep_running_in_standby <= reg_wdata[POS_KEEP_RUNNING];
      end
      if (wr_slow_ctl) begin
        slow_keep_running_in_standby <= reg_wdata[POS_KEEP_RUNNING];
      end
      if (wr_xo_ctl) begin
        crystal_enable <= reg_wdata[POS_CRYSTAL_ENABLE];
        crystal_keep_running_in_standby <= reg_wdata[POS_KEEP_RUNNING];
      end
      if (wr_xo_ctl && xo_fields_open) begin
        crystal_source_sel <= reg_wdata[POS_CRYSTAL_SOURCE_SEL];
        crystal_startup_select <= reg_wdata[POS_CRYSTAL_STARTUP_LO+:2];
      end
    end
  end

  // ----------------------------------------
  // calibration, loaded from the fuse
  // ----------------------------------------
  // fuse levels are caught by the first clock after release, never by the reset itself
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fuse_loaded <= 1'b0;
      cal_lock <= 1'b0;
      fast_osc_fine_trim_field <= 7'h00;
      fast_osc_temp_slope_field <= 4'h0;
    end else if (!fuse_loaded) begin
      fuse_loaded <= 1'b1;
      cal_lock <= fuse_calibration_lock;
      fast_osc_fine_trim_field <= fuse_pick_a ? FACTORY_FINE_TRIM_A : FACTORY_FINE_TRIM_B;
      fast_osc_temp_slope_field <= fuse_pick_a ? FACTORY_TEMP_SLOPE_A : FACTORY_TEMP_SLOPE_B;
    end else begin
      if (wr_fine) begin
        fast_osc_fine_trim_field <= reg_wdata[6:0];
      end
      if (wr_temp) begin
        fast_osc_temp_slope_field <= reg_wdata[3:0];
      end
    end
  end

  // ----------------------------------------
  // run enables and start-up lengths
  // ----------------------------------------
  logic [NUM_OSC-1:0] osc_pin;
  logic [NUM_OSC-1:0] osc_req;
  logic [NUM_OSC-1:0] osc_on;
  logic [16:0] startup_len [NUM_OSC];
  logic [16:0] gate_len [NUM_OSC];
  logic [16:0] xo_startup;

  assign osc_pin = {crystal_clk, slow_osc_clk, fast_osc_clk};
  // requests to a disabled crystal are not served
  assign osc_req = {crystal_req && crystal_enable, slow_osc_req, fast_osc_req};

  assign osc_on[IDX_FAST] = fast_keep_running_in_standby || fast_osc_req;
  assign osc_on[IDX_SLOW] = slow_keep_running_in_standby || slow_osc_req;
  assign osc_on[IDX_CRYSTAL] = crystal_enable && (crystal_keep_running_in_standby || crystal_req);

  assign xo_startup = (crystal_startup_select == 2'h0) ? XO_STARTUP_1K :
                      (crystal_startup_select == 2'h1) ? XO_STARTUP_16K :
                      (crystal_startup_select == 2'h2) ? XO_STARTUP_32K : XO_STARTUP_64K;

  assign startup_len[IDX_FAST] = fast_keep_running_in_standby ? 17'h00000 : FAST_ANALOG_STARTUP;
  assign startup_len[IDX_SLOW] = slow_keep_running_in_standby ? 17'h00000 : SLOW_ANALOG_STARTUP;
  assign startup_len[IDX_CRYSTAL] = crystal_source_sel ? 17'h00000 : xo_startup;
  assign gate_len[IDX_FAST] = FAST_GATE_CYC;
  assign gate_len[IDX_SLOW] = SLOW_GATE_CYC;
  assign gate_len[IDX_CRYSTAL] = CRYSTAL_GATE_CYC;

  // ----------------------------------------
  // per-oscillator sequencer
  // ----------------------------------------
  // the oscillator pin is sampled, so each oscillator edge is seen a few sys_clk
  // later; this only holds while sys_clk is well above twice the oscillator rate
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OSC; gi++) begin : g_osc
      logic [2:0] pin_sync;
      logic [16:0] cnt;
      occ_state_t state;
      occ_state_t next_state;
      logic [16:0] next_cnt;
      wire logic osc_edge = pin_sync[1] && !pin_sync[2];
      wire logic cnt_hit = (cnt + 17'h00001) >= startup_len[gi];
      wire logic gate_hit = (cnt + 17'h00001) >= gate_len[gi];

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_sync <= 3'h0;
        end else begin
          pin_sync <= {pin_sync[1:0], osc_pin[gi]};
        end
      end

      always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
          OCC_OFF: begin
            next_cnt = 17'h00000;
            if (osc_on[gi]) begin
              next_state = (startup_len[gi] == 17'h00000) ? OCC_READY : OCC_STARTUP;
            end
          end
          OCC_STARTUP: begin
            if (startup_len[gi] == 17'h00000) begin
              next_state = OCC_READY;
            end else if (osc_edge) begin
              next_cnt = cnt + 17'h00001;
              if (cnt_hit) begin
                next_state = OCC_READY;
              end
            end
          end
          OCC_READY: begin
            next_cnt = 17'h00000;
            if (osc_req[gi]) begin
              next_state = OCC_GATE;
            end
          end
          OCC_GATE: begin
            if (!osc_req[gi]) begin
              next_state = OCC_READY;
            end else if (osc_edge) begin
              next_cnt = cnt + 17'h00001;
              if (gate_hit) begin
                next_state = OCC_OPEN;
              end
            end
          end
          OCC_OPEN: begin
            if (!osc_req[gi]) begin
              next_state = OCC_READY;
            end
          end
          default: begin
            next_state = OCC_OFF;
            next_cnt = 17'h00000;
          end
        endcase
        if (!osc_on[gi]) begin
          next_state = OCC_OFF;
          next_cnt = 17'h00000;
        end
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          state <= OCC_OFF;
          cnt <= 17'h00000;
        end else begin
          state <= next_state;
          cnt <= next_cnt;
        end
      end

      assign stable[gi] = (state == OCC_OPEN);
    end
  endgenerate

  assign crystal_stable_flag = stable[IDX_CRYSTAL];

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_osc_run <= 1'b0;
      slow_osc_run <= 1'b0;
      crystal_run <= 1'b0;
      fast_osc_gate <= 1'b0;
      slow_osc_gate <= 1'b0;
      crystal_gate <= 1'b0;
      crystal_pin_override <= 1'b0;
    end else begin
      fast_osc_run <= osc_on[IDX_FAST];
      slow_osc_run <= osc_on[IDX_SLOW];
      crystal_run <= osc_on[IDX_CRYSTAL];
      fast_osc_gate <= stable[IDX_FAST] && osc_req[IDX_FAST];
      slow_osc_gate <= stable[IDX_SLOW] && osc_req[IDX_SLOW];
      crystal_gate <= stable[IDX_CRYSTAL] && osc_req[IDX_CRYSTAL];
      crystal_pin_override <= crystal_enable;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      OFS_CLOCK_STATUS: begin
        rd_mux[POS_STABLE_CRYSTAL] = stable[IDX_CRYSTAL];
        rd_mux[POS_STABLE_SLOW] = stable[IDX_SLOW];
        rd_mux[POS_STABLE_FAST] = stable[IDX_FAST];
      end
      OFS_FAST_OSC_CONTROL: rd_mux[POS_KEEP_RUNNING] = fast_keep_running_in_standby;
      OFS_FAST_OSC_FINE_TRIM: rd_mux[6:0] = fast_osc_fine_trim_field;
      OFS_FAST_OSC_TEMP_TRIM_LOCK: begin
        rd_mux[POS_CAL_LOCK] = cal_lock;
        rd_mux[3:0] = fast_osc_temp_slope_field;
      end
      OFS_SLOW_OSC_CONTROL: rd_mux[POS_KEEP_RUNNING] = slow_keep_running_in_standby;
      OFS_CRYSTAL_OSC_CONTROL: begin
        rd_mux[POS_CRYSTAL_STARTUP_LO+:2] = crystal_startup_select;
        rd_mux[POS_CRYSTAL_SOURCE_SEL] = crystal_source_sel;
        rd_mux[POS_KEEP_RUNNING] = crystal_keep_running_in_standby;
        rd_mux[POS_CRYSTAL_ENABLE] = crystal_enable;
      end
      default: rd_mux = 8'h00;
    endcase
  end

  // read data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

endmodule // occ_top

// ==== common/occ_pkg.sv ====
// oscillator control and calibration: offsets, field positions, reset values, counts
// assumes an 8-bit register port and byte-wide registers at the listed offsets
package occ_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CLOCK_STATUS = 8'h03;
  localparam logic [7:0] OFS_FAST_OSC_CONTROL = 8'h10;
  localparam logic [7:0] OFS_FAST_OSC_FINE_TRIM = 8'h11;
  localparam logic [7:0] OFS_FAST_OSC_TEMP_TRIM_LOCK = 8'h12;
  localparam logic [7:0] OFS_SLOW_OSC_CONTROL = 8'h18;
  localparam logic [7:0] OFS_CRYSTAL_OSC_CONTROL = 8'h1C;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int POS_KEEP_RUNNING = 1;
  localparam int POS_CRYSTAL_ENABLE = 0;
  localparam int POS_CRYSTAL_SOURCE_SEL = 2;
  localparam int POS_CRYSTAL_STARTUP_LO = 4;
  localparam int POS_CAL_LOCK = 7;
  localparam int POS_STABLE_CRYSTAL = 6;
  localparam int POS_STABLE_SLOW = 5;
  localparam int POS_STABLE_FAST = 4;

  // ----------------------------------------
  // reset values and counts
  // ----------------------------------------
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [16:0] FAST_GATE_CYC = 17'h00004;
  localparam logic [16:0] SLOW_GATE_CYC = 17'h00004;
  localparam logic [16:0] CRYSTAL_GATE_CYC = 17'h00002;
  localparam int NUM_OSC = 3;
  localparam int IDX_FAST = 0;
  localparam int IDX_SLOW = 1;
  localparam int IDX_CRYSTAL = 2;

  typedef enum logic [4:0] {
    OCC_OFF = 5'b00001,
    OCC_STARTUP = 5'b00010,
    OCC_READY = 5'b00100,
    OCC_GATE = 5'b01000,
    OCC_OPEN = 5'b10000
  } occ_state_t;

endpackage

// ==== dv/occ_osc_model.sv ====
// oscillator source model for the crystal and internal oscillator pins
// assumes run comes from the block's analog enable outputs
`timescale 1ns/100ps
module occ_osc_model #(
  parameter real HALF = 20.0
) (
  input wire logic run, // analog run enable
  output logic clk // oscillator pin
);
  // a stopped source stands low so no stray edge reaches the edge counters
  initial begin
    clk = 1'b0;
    forever begin
      #(HALF);
      clk = run ? ~clk : 1'b0;
    end
  end
endmodule // occ_osc_model

// ==== dv/occ_top_sva.sv ====
// checker: timing and access relations seen at the oscillator control ports
// assumes oscillator periods near 40 ns and fuse levels held steady out of reset
`timescale 1ns/100ps
module occ_top_sva
  import occ_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire logic rst_n, // reset, active low
  input wire logic [7:0] reg_addr, // offset
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic protect_unlock, // unlock
  input wire logic fuse_calibration_lock, // fuse lock
  input wire logic fast_osc_req, // fast request
  input wire logic slow_osc_req, // slow request
  input wire logic crystal_req, // crystal request
  input wire logic crystal_run, // crystal enable
  input wire logic fast_osc_gate, // fast gate
  input wire logic slow_osc_gate, // slow gate
  input wire logic crystal_gate, // crystal gate
  input wire logic crystal_pin_override, // pin override
  input wire logic [6:0] fast_osc_fine_trim_field, // fine trim
  input wire logic [3:0] fast_osc_temp_slope_field // slope
);
  logic armed;
  logic armed2;
  logic [5:0] fast_cnt;
  wire wr_fine = reg_wr & protect_unlock & (reg_addr == OFS_FAST_OSC_FINE_TRIM);
  wire wr_slope = reg_wr & protect_unlock & (reg_addr == OFS_FAST_OSC_TEMP_TRIM_LOCK);
  wire wr_xo = reg_wr & protect_unlock & (reg_addr == OFS_CRYSTAL_OSC_CONTROL);
  // armed2 skips the fuse load edge, where trims change with no write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
      armed2 <= 1'b0;
      fast_cnt <= 6'h00;
    end else begin
      armed <= 1'b1;
      armed2 <= armed;
      fast_cnt <= !fast_osc_req ? 6'h00 : ((fast_cnt == 6'h3F) ? fast_cnt : fast_cnt + 6'h01);
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_fine_wr;
    armed2 && wr_fine && !fuse_calibration_lock;
  endsequence
  sequence s_slope_wr;
    armed2 && wr_slope && !fuse_calibration_lock;
  endsequence
  a_fine_trim_write: assert property (s_fine_wr |=> fast_osc_fine_trim_field == $past(reg_wdata[6:0]))
    else $error("fine trim write lost");
  a_slope_trim_write: assert property (s_slope_wr |=> fast_osc_temp_slope_field == $past(reg_wdata[3:0]))
    else $error("slope write lost");
  a_trim_lock_holds: assert property (armed2 && fuse_calibration_lock |->
    $stable(fast_osc_fine_trim_field) && $stable(fast_osc_temp_slope_field)) else $error("locked trim changed");
  a_override_unlock: assert property (armed2 && $changed(crystal_pin_override) |->
    $past(wr_xo) || $past(wr_xo, 2)) else $error("override changed without write");
  a_xtal_run_enable: assert property (crystal_run |->
    $past(crystal_pin_override) or ##[0:1] crystal_pin_override) else $error("crystal runs while disabled");
  a_fast_gate_req: assert property (fast_osc_gate |->
    fast_osc_req || $past(fast_osc_req) || $past(fast_osc_req, 2)) else $error("fast gate open unrequested");
  a_slow_gate_req: assert property (slow_osc_gate |->
    slow_osc_req || $past(slow_osc_req) || $past(slow_osc_req, 2)) else $error("slow gate open unrequested");
  a_xtal_gate_req: assert property (crystal_gate |->
    crystal_req || $past(crystal_req) || $past(crystal_req, 2)) else $error("crystal gate open unrequested");
  a_fast_gate_delay: assert property ($rose(fast_osc_gate) |-> fast_cnt >= 6'h1C)
    else $error("fast gate opened early");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
endmodule // occ_top_sva
bind occ_top occ_top_sva u_sva (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .protect_unlock, .fuse_calibration_lock, .fast_osc_req, .slow_osc_req, .crystal_req, .crystal_run,
  .fast_osc_gate, .slow_osc_gate, .crystal_gate, .crystal_pin_override, .fast_osc_fine_trim_field,
  .fast_osc_temp_slope_field);

// ==== dv/occ_top_tb.sv ====
// self-checking bench for the oscillator control block
// assumes source models drive the oscillator pins and stop while disabled
`timescale 1ns/100ps
module occ_top_tb;
  import occ_pkg::*;
  localparam int P = 10; // crystal and fast period in system cycles
  localparam int PS = 13; // slow period
  logic sys_clk, rst_n, reg_wr, reg_rd, protect_unlock, fuse_calibration_lock;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v, d;
  logic [1:0] fuse_frequency_select;
  logic fast_osc_clk, slow_osc_clk, crystal_clk, fast_osc_req, slow_osc_req, crystal_req;
  logic fast_osc_run, slow_osc_run, crystal_run, fast_osc_gate, slow_osc_gate, crystal_gate, crystal_pin_override;
  logic [6:0] fast_osc_fine_trim_field;
  logic [3:0] fast_osc_temp_slope_field;
  wire [2:0] gates = {crystal_gate, slow_osc_gate, fast_osc_gate};
  int miscompares = 0, num_checks = 0, cyc = 0, n, seed = 32'hDD72AE7B;
  int st[4] = '{4, 8, 12, 16};
  // only the crystal counts are shortened; analog start-up and set B trims keep their defaults
  occ_top #(.XO_STARTUP_1K(17'h00004), .XO_STARTUP_16K(17'h00008), .XO_STARTUP_32K(17'h0000C),
    .XO_STARTUP_64K(17'h00010), .FACTORY_FINE_TRIM_A(7'h2A)) DUT (.sys_clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata,
    .protect_unlock, .fuse_frequency_select, .fuse_calibration_lock, .fast_osc_clk, .slow_osc_clk, .crystal_clk,
    .fast_osc_req, .slow_osc_req, .crystal_req, .fast_osc_run, .slow_osc_run, .crystal_run, .fast_osc_gate,
    .slow_osc_gate, .crystal_gate, .crystal_pin_override, .fast_osc_fine_trim_field, .fast_osc_temp_slope_field);
  occ_osc_model #(.HALF(20.0)) u_fast (.run(fast_osc_run), .clk(fast_osc_clk));
  occ_osc_model #(.HALF(26.0)) u_slow (.run(slow_osc_run), .clk(slow_osc_clk));
  occ_osc_model #(.HALF(20.0)) u_xtal (.run(crystal_run), .clk(crystal_clk));
  // ----------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      complete_run;
    end
  end
  task automatic complete_run;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rng(input string nm, input int lo, input int hi, input int got);
    num_checks++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("ERROR %s expected %0d to %0d seen %0d", nm, lo, hi, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] dat, input logic u);
    reg_addr <= a;
    reg_wdata <= dat;
    protect_unlock <= u;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] dat);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    dat = reg_rdata;
  endtask
  task automatic do_reset(input logic [1:0] fs, input logic lk);
    rst_n <= 1'b0;
    fuse_frequency_select <= fs;
    fuse_calibration_lock <= lk;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic wait_gate(input int i, output int c);
    c = 0;
    while (gates[i] !== 1'b1 && c < 2000) begin
      @(posedge sys_clk);
      c++;
    end
  endtask
  task automatic xo_off(input logic [7:0] cfg);
    crystal_req <= 1'b0;
    wr(OFS_CRYSTAL_OSC_CONTROL, cfg, 1'b1);
    v = 8'h40;
    for (int t = 0; t < 20 && v[6] !== 1'b0; t++) begin
      rd(OFS_CLOCK_STATUS, v);
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {reg_wr, reg_rd, protect_unlock, fast_osc_req, slow_osc_req, crystal_req} = 6'h00;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    rst_n = 1'b0;
    fuse_frequency_select = 2'b01;
    fuse_calibration_lock = 1'b0;
    do_reset(2'b01, 1'b0);
    chk("fine_rst", 8'h2A, {1'b0, fast_osc_fine_trim_field});
    chk("slope_rst", 8'h08, {4'h0, fast_osc_temp_slope_field});
    rd(OFS_SLOW_OSC_CONTROL, v);
    chk("slow_ctrl_rst", RST_CONTROL, v);
    rd(8'h05, v);
    chk("unmapped", 8'h00, v);
    repeat (6) begin
      d = 8'($random(seed));
      wr(OFS_FAST_OSC_FINE_TRIM, d, 1'b1);
      rd(OFS_FAST_OSC_FINE_TRIM, v);
      chk("fine_rd", {1'b0, d[6:0]}, v);
      chk("fine_port", {1'b0, d[6:0]}, {1'b0, fast_osc_fine_trim_field});
      wr(OFS_FAST_OSC_TEMP_TRIM_LOCK, d, 1'b1);
      rd(OFS_FAST_OSC_TEMP_TRIM_LOCK, v);
      chk("slope_rd", {4'h0, d[3:0]}, v);
    end
    wr(OFS_CRYSTAL_OSC_CONTROL, 8'h03, 1'b0);
    rd(OFS_CRYSTAL_OSC_CONTROL, v);
    chk("xo_locked_wr", RST_CONTROL, v);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_CRYSTAL_OSC_CONTROL, {2'b00, k[1:0], 4'h0}, 1'b1);
      wr(OFS_CRYSTAL_OSC_CONTROL, {2'b00, k[1:0], 4'h1}, 1'b1);
      crystal_req <= 1'b1;
      wait_gate(2, n);
      rng("xo_startup", st[k] * P, (st[k] + 3) * P + 12, n);
      rd(OFS_CLOCK_STATUS, v);
      chk("xo_stable", 8'h40, v & 8'h40);
      chk("pin_override", 8'h01, {7'h00, crystal_pin_override});
      wr(OFS_CRYSTAL_OSC_CONTROL, {2'b00, ~k[1:0], 4'h5}, 1'b1);
      rd(OFS_CRYSTAL_OSC_CONTROL, v);
      chk("xo_frozen", {2'b00, k[1:0], 4'h1}, v);
      xo_off({2'b00, k[1:0], 4'h0});
      chk("xo_off", 8'h00, v & 8'h40);
    end
    wr(OFS_CRYSTAL_OSC_CONTROL, 8'h34, 1'b1);
    wr(OFS_CRYSTAL_OSC_CONTROL, 8'h35, 1'b1);
    crystal_req <= 1'b1;
    wait_gate(2, n);
    rng("ext_clock", 0, 3 * P + 12, n);
    xo_off(8'h00);
    wr(OFS_CRYSTAL_OSC_CONTROL, 8'h03, 1'b1);
    repeat (100) @(posedge sys_clk);
    chk("xo_forced", 8'h01, {7'h00, crystal_run});
    rd(OFS_CLOCK_STATUS, v);
    chk("forced_unstable", 8'h00, v & 8'h40);
    chk("xo_gate_idle", 8'h00, {7'h00, crystal_gate});
    crystal_req <= 1'b1;
    wait_gate(2, n);
    rng("xo_warm", 0, 3 * P + 8, n);
    crystal_req <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("xo_gate_drop", 8'h00, {7'h00, crystal_gate});
    chk("xo_still_run", 8'h01, {7'h00, crystal_run});
    wr(OFS_FAST_OSC_CONTROL, 8'h02, 1'b1);
    repeat (60) @(posedge sys_clk);
    chk("fast_forced", 8'h01, {7'h00, fast_osc_run});
    chk("fast_gate_idle", 8'h00, {7'h00, fast_osc_gate});
    fast_osc_req <= 1'b1;
    wait_gate(0, n);
    rng("fast_gate", 3 * P - 2, 5 * P + 12, n);
    fast_osc_req <= 1'b0;
    slow_osc_req <= 1'b1;
    wait_gate(1, n);
    // sixteen analog start-up edges plus four gate edges
    rng("slow_gate", 19 * PS, 21 * PS + 12, n);
    chk("slow_run", 8'h01, {7'h00, slow_osc_run});
    slow_osc_req <= 1'b0;
    do_reset(2'b00, 1'b1);
    chk("fine_set_b", 8'h40, {1'b0, fast_osc_fine_trim_field});
    rd(OFS_FAST_OSC_TEMP_TRIM_LOCK, v);
    chk("lock_slope_b", 8'h88, v);
    wr(OFS_FAST_OSC_FINE_TRIM, 8'h7F, 1'b1);
    chk("fine_locked", 8'h40, {1'b0, fast_osc_fine_trim_field});
    complete_run;
  end
endmodule // occ_top_tb
